// ---- qrs_term_model.sv ----
/* Remote serial terminal: sends and collects 8-bit, one-stop frames.
   Assumes BIT, in mclk cycles, matches the port's configured bit time. */
`timescale 1ns/1ps
module qrs_term_model #(
  parameter int BIT = 434
) (
  input wire mclk,
  input wire txd,
  output logic rxd
);
  logic [7:0] rx_q[$];
  logic [7:0] b;
  int i;
  // Line rests at mark between frames
  initial rxd = 1'b1;
  // sample mid-bit, LSB first; a low stop bit drops the character
  initial
  begin
    forever
    begin
      @(negedge txd);
      repeat (BIT / 2) @(posedge mclk);
      for (i = 0; i < 8; i++)
      begin
        repeat (BIT) @(posedge mclk);
        b[i] = txd;
      end
      repeat (BIT) @(posedge mclk);
      if (txd === 1'b1)
        rx_q.push_back(b);
    end
  end
  // start, eight data bits LSB first, one stop
  task automatic send(input logic [7:0] v);
    int k;
    @(posedge mclk);
    rxd <= 1'b0;
    repeat (BIT) @(posedge mclk);
    for (k = 0; k < 8; k++)
    begin
      rxd <= v[k];
      repeat (BIT) @(posedge mclk);
    end
    rxd <= 1'b1;
    repeat (BIT) @(posedge mclk);
  endtask
endmodule // qrs_term_model

// ---- qrs_uart.v ----
/*
  Four-port RS-422 serial adapter: host I/O decode and four UART cores.
  Assumes byte-wide host I/O strobes synchronous to mclk, base addresses
  supplied by system configuration, and line inputs already synchronous.
*/
`timescale 1ns/1ps
`include "qrs_uart_regs.vh"

module qrs_port (
  input wire mclk,
  input wire resetn,
  input wire tick16,
  input wire sel,
  input wire wr,
  input wire rd,
  input wire [2:0] off,
  input wire [7:0] wdata,
  output reg [7:0] rdata,
  input wire auto_mode,
  input wire rxd,
  output reg txd,
  output wire tx_de
);
  localparam S_IDLE = 3'd0;
  localparam S_START = 3'd1;
  localparam S_DATA = 3'd2;
  localparam S_PAR = 3'd3;
  localparam S_STOP = 3'd4;
  localparam S_HOLD = 3'd5;

  // Bits in a character for the format field
  function [3:0] char_len;
    input [1:0] dls;
    begin
      char_len = {2'b00, dls} + 4'd5;
    end
  endfunction

  // Parity bit for data, odd/even/stick modes
  function par_bit;
    input [7:0] d;
    input even;
    input stick;
    begin
      par_bit = stick ? ~even : (even ? ^d : ~^d);
    end
  endfunction

  reg [15:0] div_r;
  reg [7:0] fmt_r, hsk_r, en_r;
  reg [15:0] dcnt_r;
  reg btick_r;
  wire dsel = fmt_r[`QRS_FMT_DLS];
  wire [3:0] nbits = char_len(fmt_r[1:0]);
  wire [7:0] dmask = 8'hFF >> (4'd8 - nbits);
  wire wr_data = sel && wr && off == `QRS_OFF_DATA && !dsel;
  wire rd_data = sel && rd && off == `QRS_OFF_DATA && !dsel;

  // Divisor counter: one pulse per 16x sample period
  // divide reference by divisor, 16 samples per bit
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      dcnt_r <= 16'h0000;
      btick_r <= 1'b0;
    end
    else
    begin
      btick_r <= 1'b0;
      if (tick16)
      begin
        if (dcnt_r + 16'h0001 >= div_r)
        begin
          dcnt_r <= 16'h0000;
          btick_r <= 1'b1;
        end
        else
          dcnt_r <= dcnt_r + 16'h0001;
      end
    end
  end

  // Two-entry receive buffer: {framing, parity, data}
  reg [9:0] fifo_m [0:1];
  reg wp_r, rp_r;
  reg [1:0] cnt_r;
  wire push_valid;
  wire push_ready = cnt_r != 2'd2;
  wire pop_valid = cnt_r != 2'd0;
  // a data read pops one entry, or none while the buffer is empty
  wire pop_ready = rd_data;
  wire [9:0] push_word;
  wire [9:0] head = fifo_m[rp_r];
  wire push = push_valid && push_ready;
  wire pop = pop_valid && pop_ready;

  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'd0;
    end
    else
    begin
      if (push)
        wp_r <= ~wp_r;
      if (pop)
        rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  // Storage needs no reset; reads are gated by the count
  always @(posedge mclk)
  begin
    if (push)
      fifo_m[wp_r] <= push_word;
  end

  // Receiver
  reg [2:0] rst_r;
  reg [3:0] rsmp_r, rbit_r;
  reg [7:0] rsh_r;
  reg rpe_r, rfe_r, ovr_r;
  assign push_valid = rst_r == S_HOLD;
  assign push_word = {rfe_r, rpe_r, (rsh_r >> (4'd8 - nbits)) & dmask};
  wire rd_flags = sel && rd && off == `QRS_OFF_FLAGS;
  // A start edge while a character waits in S_HOLD on a full buffer cannot be taken
  wire ovr_set = rst_r == S_HOLD && !push_ready && !rxd;

  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      rst_r <= S_IDLE;
      rsmp_r <= 4'h0;
      rbit_r <= 4'h0;
      rsh_r <= 8'h00;
      rpe_r <= 1'b0;
      rfe_r <= 1'b0;
      ovr_r <= 1'b0;
    end
    else
    begin
      // Overrun is sticky; a new event beats the clearing read
      if (ovr_set)
        ovr_r <= 1'b1;
      else if (rd_flags)
        ovr_r <= 1'b0;
      if (btick_r)
        rsmp_r <= rsmp_r + 4'h1;
      case (rst_r)
        S_IDLE:
          if (btick_r && !rxd)
          begin
            rst_r <= S_START;
            rsmp_r <= 4'h0;
          end
        S_START:
          // Recheck mid-bit to reject glitches
          if (btick_r && rsmp_r == `QRS_HALF_BIT)
          begin
            rst_r <= rxd ? S_IDLE : S_DATA;
            rsmp_r <= 4'h0;
            rbit_r <= 4'h0;
            rpe_r <= 1'b0;
          end
        S_DATA:
          if (btick_r && rsmp_r == `QRS_OVERSAMPLE)
          begin
            rsh_r <= {rxd, rsh_r[7:1]};
            rbit_r <= rbit_r + 4'h1;
            if (rbit_r + 4'h1 == nbits)
              rst_r <= fmt_r[`QRS_FMT_PAR_EN] ? S_PAR : S_STOP;
          end
        S_PAR:
          // check received parity against the mode
          if (btick_r && rsmp_r == `QRS_OVERSAMPLE)
          begin
            rpe_r <= rxd != par_bit((rsh_r >> (4'd8 - nbits)) & dmask,
              fmt_r[`QRS_FMT_PAR_EVEN], fmt_r[`QRS_FMT_PAR_STICK]);
            rst_r <= S_STOP;
          end
        S_STOP:
          if (btick_r && rsmp_r == `QRS_OVERSAMPLE)
          begin
            rfe_r <= !rxd;
            rst_r <= S_HOLD;
          end
        S_HOLD:
          // Stalls here while the buffer is full
          if (push_ready)
            rst_r <= S_IDLE;
        default:
          rst_r <= S_IDLE;
      endcase
    end
  end

  // Transmitter: holding register plus shifter
  reg [7:0] thr_r, tsh_r;
  reg thr_full_r;
  reg [2:0] tst_r;
  reg [3:0] tsmp_r, tbit_r;
  reg tstop_r;
  wire tx_busy = tst_r != S_IDLE;

  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      thr_r <= 8'h00;
      thr_full_r <= 1'b0;
      tst_r <= S_IDLE;
      tsh_r <= 8'h00;
      tsmp_r <= 4'h0;
      tbit_r <= 4'h0;
      tstop_r <= 1'b0;
      txd <= 1'b1;
    end
    else
    begin
      // no data load while divisor select is set
      if (wr_data)
      begin
        thr_r <= wdata;
        thr_full_r <= 1'b1;
      end
      if (btick_r)
        tsmp_r <= tsmp_r + 4'h1;
      case (tst_r)
        S_IDLE:
        begin
          txd <= 1'b1;
          if (btick_r && thr_full_r && !wr_data)
          begin
            tsh_r <= thr_r & dmask;
            thr_full_r <= 1'b0;
            tst_r <= S_START;
            tsmp_r <= 4'h0;
            txd <= 1'b0;
          end
        end
        S_START:
          if (btick_r && tsmp_r == `QRS_OVERSAMPLE)
          begin
            tst_r <= S_DATA;
            tbit_r <= 4'h1;
            txd <= tsh_r[0];
          end
        S_DATA:
          if (btick_r && tsmp_r == `QRS_OVERSAMPLE)
          begin
            tbit_r <= tbit_r + 4'h1;
            if (tbit_r == nbits)
            begin
              // parity bit from the format mode
              tst_r <= fmt_r[`QRS_FMT_PAR_EN] ? S_PAR : S_STOP;
              txd <= fmt_r[`QRS_FMT_PAR_EN] ? par_bit(tsh_r,
                fmt_r[`QRS_FMT_PAR_EVEN], fmt_r[`QRS_FMT_PAR_STICK]) : 1'b1;
              tstop_r <= 1'b0;
            end
            else
              txd <= tsh_r[tbit_r[2:0]];
          end
        S_PAR:
          if (btick_r && tsmp_r == `QRS_OVERSAMPLE)
          begin
            tst_r <= S_STOP;
            txd <= 1'b1;
          end
        S_STOP:
          if (btick_r && tsmp_r == `QRS_OVERSAMPLE)
          begin
            if (fmt_r[`QRS_FMT_STOP2] && !tstop_r)
              tstop_r <= 1'b1;
            else
              tst_r <= S_IDLE;
          end
        default:
          tst_r <= S_IDLE;
      endcase
    end
  end

  // automatic mode drives the line whenever data is pending
  assign tx_de = auto_mode ? (tx_busy || thr_full_r) : hsk_r[`QRS_HSK_RTS];

  // Host writes to control registers
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      div_r <= `QRS_RST_DIV;
      fmt_r <= `QRS_RST_FMT;
      hsk_r <= `QRS_RST_HSK;
      en_r <= `QRS_RST_EN;
    end
    else if (sel && wr)
    begin
      case (off)
        // divisor select reroutes offsets 0 and 1
        `QRS_OFF_DATA:
          if (dsel)
            div_r[7:0] <= wdata;
        `QRS_OFF_DIVH:
          if (dsel)
            div_r[15:8] <= wdata;
          else
            en_r <= wdata;
        `QRS_OFF_FMT:
          fmt_r <= wdata;
        `QRS_OFF_HSK:
          hsk_r <= wdata;
        default:
          hsk_r <= hsk_r;
      endcase
    end
  end

  // Flags and pending source
  // ready while the buffer holds a character
  // holding empty, and holding empty with shifter idle, shown separately
  wire [7:0] flags = {1'b0, !tx_busy && !thr_full_r, !thr_full_r, 1'b0,
    pop_valid && head[9], pop_valid && head[8], ovr_r, pop_valid};
  // receive first, then holding empty, else none
  // receive code drops once the buffer empties
  wire [7:0] ident = (pop_valid && en_r[0]) ? `QRS_IDENT_RX :
    (!thr_full_r && en_r[1]) ? `QRS_IDENT_THR : `QRS_IDENT_NONE;

  // Read multiplexer; unused offsets read zero
  always @*
  begin
    case (off)
      `QRS_OFF_DATA: rdata = dsel ? div_r[7:0] : (pop_valid ? head[7:0] : 8'h00);
      `QRS_OFF_DIVH: rdata = dsel ? div_r[15:8] : en_r;
      `QRS_OFF_IDENT: rdata = ident;
      `QRS_OFF_FMT: rdata = fmt_r;
      `QRS_OFF_HSK: rdata = hsk_r;
      `QRS_OFF_FLAGS: rdata = flags;
      default: rdata = 8'h00;
    endcase
  end
endmodule // qrs_port

module qrs_uart #(
  // Arbitrary identification values
  parameter [15:0] VENDOR_CODE = 16'hA5A5,
  parameter [15:0] DEVICE_CODE = 16'h5A01
) (
  input wire mclk,
  input wire resetn,
  input wire [15:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata,
  output reg io_rvalid,
  input wire [63:0] base_addr,
  output wire [15:0] vendor_code,
  output wire [15:0] device_code,
  input wire fourfold_clock_range,
  input wire [3:0] auto_mode,
  input wire [3:0] rxd,
  output wire [3:0] txd,
  output wire [3:0] tx_de
);
  assign vendor_code = VENDOR_CODE;
  assign device_code = DEVICE_CODE;

  // Reference tick by phase accumulation; avoids a separate 1.8432 MHz clock
  reg [31:0] acc_r;
  reg ref_r;
  // range select multiplies the reference by four
  wire [31:0] step = fourfold_clock_range ? `QRS_REF_HZ * `QRS_FOURFOLD : `QRS_REF_HZ;
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      acc_r <= 32'h00000000;
      ref_r <= 1'b0;
    end
    else if (acc_r + step >= `QRS_MCLK_HZ)
    begin
      acc_r <= acc_r + step - `QRS_MCLK_HZ;
      ref_r <= 1'b1;
    end
    else
    begin
      acc_r <= acc_r + step;
      ref_r <= 1'b0;
    end
  end

  wire [31:0] prd;
  wire [3:0] hit;
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_port
      // first window 16 bytes, others 8
      wire [3:0] span = (i == 0) ? `QRS_SPAN_WIDE_BITS : `QRS_SPAN_NARROW_BITS;
      assign hit[i] = (io_addr >> span) == (base_addr[16*i+15:16*i] >> span);
      // Upper half of the wide window is reserved and inert
      wire live = hit[i] && !(i == 0 && io_addr[3]);
      qrs_port u_port (
        .mclk(mclk),
        .resetn(resetn),
        .tick16(ref_r),
        .sel(live),
        .wr(io_wr),
        .rd(io_rd),
        .off(io_addr[2:0]),
        .wdata(io_wdata),
        .rdata(prd[8*i+7:8*i]),
        .auto_mode(auto_mode[i]),
        .rxd(rxd[i]),
        .txd(txd[i]),
        .tx_de(tx_de[i])
      );
    end
  endgenerate

  // Registered read data, one cycle after the strobe; reserved reads zero
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      io_rdata <= 8'h00;
      io_rvalid <= 1'b0;
    end
    else
    begin
      io_rvalid <= io_rd;
      // Held between reads so a slow host still sees the last answer
      if (io_rd)
        io_rdata <= hit[0] ? (io_addr[3] ? 8'h00 : prd[7:0]) :
          hit[1] ? prd[15:8] : hit[2] ? prd[23:16] : hit[3] ? prd[31:24] : 8'h00;
    end
  end
endmodule // qrs_uart

// ---- qrs_uart_checker.sv ----
/* Port-level checker for qrs_uart: host read timing, decode, line pins.
   Assumes it is bound to qrs_uart and sees only that module's ports. */
`timescale 1ns/1ps
module qrs_uart_checker #(
  parameter [15:0] VENDOR_CODE = 16'hA5A5,
  parameter [15:0] DEVICE_CODE = 16'h5A01
) (
  input wire mclk,
  input wire resetn,
  input wire [15:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  input wire [7:0] io_rdata,
  input wire io_rvalid,
  input wire [63:0] base_addr,
  input wire [15:0] vendor_code,
  input wire [15:0] device_code,
  input wire fourfold_clock_range,
  input wire [3:0] auto_mode,
  input wire [3:0] rxd,
  input wire [3:0] txd,
  input wire [3:0] tx_de
);
  wire [3:0] win;
  wire reg_hit;
  // Window match on bits 15:3; port 0 offsets 8..15 fail it as base is 16-aligned
  assign win[0] = io_addr[15:3] == base_addr[15:3];
  assign win[1] = io_addr[15:3] == base_addr[31:19];
  assign win[2] = io_addr[15:3] == base_addr[47:35];
  assign win[3] = io_addr[15:3] == base_addr[63:51];
  assign reg_hit = (|win) && (io_addr[2:0] < 3'h6);
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_lone_read; io_rd ##1 !io_rd; endsequence
  sequence s_one_valid; io_rvalid ##1 !io_rvalid; endsequence
  sequence s_start; $fell(txd[0]); endsequence
  property p_rvalid_pulse; s_lone_read |-> s_one_valid; endproperty
  property p_rvalid_cause; io_rvalid |-> $past(io_rd); endproperty
  property p_rdata_hold; !io_rd |=> $stable(io_rdata); endproperty
  property p_unmapped; io_rd && !reg_hit |=> io_rdata == 8'h00; endproperty
  property p_ids; vendor_code == VENDOR_CODE && device_code == DEVICE_CODE; endproperty
  property p_reset_idle; $rose(resetn) |-> txd == 4'hF && tx_de == 4'h0 && !io_rvalid;
  endproperty
  property p_auto_de; (auto_mode & ~txd & ~tx_de) == 4'h0; endproperty
  property p_start_min; s_start |-> (!txd[0]) [*8]; endproperty
  a_rvalid_pulse:
    assert property (p_rvalid_pulse) else $error("read answer is not one pulse");
  a_rvalid_cause:
    assert property (p_rvalid_cause) else $error("read answer without a read");
  a_rdata_hold:
    assert property (p_rdata_hold) else $error("read data moved without a read");
  a_unmapped:
    assert property (p_unmapped) else $error("empty address gave nonzero data");
  a_ids:
    assert property (p_ids) else $error("identification codes wrong");
  a_reset_idle:
    assert property (p_reset_idle) else $error("line not idle after reset");
  a_auto_de:
    assert property (p_auto_de) else $error("driver off while sending in auto mode");
  a_start_min:
    assert property (p_start_min) else $error("start bit far too short");
endmodule // qrs_uart_checker

bind qrs_uart qrs_uart_checker #(.VENDOR_CODE(VENDOR_CODE), .DEVICE_CODE(DEVICE_CODE)) u_chk (
  .mclk(mclk), .resetn(resetn), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
  .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid), .base_addr(base_addr),
  .vendor_code(vendor_code), .device_code(device_code),
  .fourfold_clock_range(fourfold_clock_range), .auto_mode(auto_mode), .rxd(rxd),
  .txd(txd), .tx_de(tx_de));

// ---- qrs_uart_regs.vh ----
/*
  Constants for the four-port serial adapter: register offsets, field
  positions, reset values and baud timing. Included by the design file.
*/
`ifndef QRS_UART_REGS_VH
`define QRS_UART_REGS_VH

// Register offsets inside one port window
`define QRS_OFF_DATA 3'h0
`define QRS_OFF_DIVH 3'h1
`define QRS_OFF_IDENT 3'h2
`define QRS_OFF_FMT 3'h3
`define QRS_OFF_HSK 3'h4
`define QRS_OFF_FLAGS 3'h5
// First port spans 16 bytes, the others 8
`define QRS_SPAN_WIDE_BITS 4'd4
`define QRS_SPAN_NARROW_BITS 4'd3

// Frame format control fields
`define QRS_FMT_DLS 7
`define QRS_FMT_STOP2 2
`define QRS_FMT_PAR_EN 3
`define QRS_FMT_PAR_EVEN 4
`define QRS_FMT_PAR_STICK 5
`define QRS_FMT_BREAK 6
// Handshake line control: request-to-send
`define QRS_HSK_RTS 1
// Condition flags
`define QRS_FLG_READY 0
`define QRS_FLG_OVERRUN 1
`define QRS_FLG_PARITY 2
`define QRS_FLG_FRAMING 3
`define QRS_FLG_THR_EMPTY 5
`define QRS_FLG_TX_IDLE 6
// Pending source codes
`define QRS_IDENT_NONE 8'h01
`define QRS_IDENT_THR 8'h02
`define QRS_IDENT_RX 8'h04

// Reset values
`define QRS_RST_DIV 16'h000C
`define QRS_RST_FMT 8'h03
`define QRS_RST_HSK 8'h00
`define QRS_RST_EN 8'h00

// Timing: 200 MHz core clock, 1.8432 MHz reference, 16x oversampling
`define QRS_MCLK_HZ 32'd200000000
`define QRS_REF_HZ 32'd1843200
`define QRS_FOURFOLD 3'd4
`define QRS_OVERSAMPLE 4'hF
`define QRS_HALF_BIT 4'h7

`endif

// ---- qrs_uart_tb.sv ----
/* Self-checking bench for qrs_uart: register rows, then transfers.
   Assumes the terminal model on port 0; ports 1 to 3 loop their lines back. */
`timescale 1ns/1ps
module qrs_uart_tb;
  localparam [15:0] B0 = 16'h1000;
  localparam [15:0] B1 = 16'h2008;
  localparam [15:0] B2 = 16'hFFF8;
  localparam [15:0] B3 = 16'h0100;
  localparam int NROW = 25;
  typedef struct {logic w; logic [15:0] a; logic [7:0] v;} qrs_row_t;
  reg mclk = 1'b0;
  reg resetn = 1'b0;
  reg [15:0] io_addr = 16'h0000;
  reg io_wr = 1'b0;
  reg io_rd = 1'b0;
  reg [7:0] io_wdata = 8'h00;
  reg [3:0] auto_mode = 4'h1;
  reg range_x4 = 1'b1;
  wire [7:0] io_rdata;
  wire io_rvalid;
  wire [3:0] txd;
  wire [3:0] tx_de;
  wire term_rxd;
  int bad_count = 0;
  int n_compared = 0;
  int j;
  logic [7:0] d;
  // Register rows: write, or read with the value it must return
  qrs_row_t rows [0:NROW-1] = '{
    '{1'b0, B0 + 16'h5, 8'h60}, '{1'b0, B0 + 16'h2, 8'h01}, '{1'b0, B0 + 16'h3, 8'h03},
    '{1'b1, B0 + 16'h3, 8'h83}, '{1'b0, B0, 8'h0C}, '{1'b0, B0 + 16'h1, 8'h00},
    '{1'b1, B0 + 16'h1, 8'h5A}, '{1'b0, B0 + 16'h1, 8'h5A}, '{1'b1, B0 + 16'h1, 8'h00},
    '{1'b1, B0, 8'h01}, '{1'b0, B0, 8'h01}, '{1'b1, B0 + 16'h3, 8'h03},
    '{1'b0, B0 + 16'h3, 8'h03}, '{1'b0, B0 + 16'h1, 8'h00}, '{1'b1, B0 + 16'h1, 8'h01},
    '{1'b1, B0 + 16'h4, 8'h02}, '{1'b0, B0 + 16'h4, 8'h02}, '{1'b1, B0 + 16'h4, 8'h00},
    '{1'b0, B0 + 16'h8, 8'h00}, '{1'b0, B0 + 16'h6, 8'h00}, '{1'b0, B1 + 16'h3, 8'h03},
    '{1'b0, B2 + 16'h3, 8'h03}, '{1'b1, B3 + 16'h3, 8'h1F}, '{1'b0, B3 + 16'h3, 8'h1F},
    '{1'b0, 16'h3000, 8'h00}};

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  qrs_uart u_dut (
    .mclk(mclk), .resetn(resetn), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
    .base_addr({B3, B2, B1, B0}), .vendor_code(), .device_code(),
    .fourfold_clock_range(range_x4), .auto_mode(auto_mode), .rxd({txd[3:1], term_rxd}),
    .txd(txd), .tx_de(tx_de));

  // Divisor 1 in the fourfold range gives 434 cycles a bit
  qrs_term_model #(.BIT(434)) u_term (.mclk(mclk), .txd(txd[0]), .rxd(term_rxd));

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge mclk);
    io_addr <= a;
    io_wdata <= v;
    io_wr <= 1'b1;
    @(posedge mclk);
    io_wr <= 1'b0;
  endtask

  // Answer is taken one edge after the strobe, once that edge has landed
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge mclk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge mclk);
    io_rd <= 1'b0;
    #1;
    v = io_rvalid ? io_rdata : 8'hXX;
  endtask

  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Whole run is near 28000 cycles; nearly three times that means a hang
  initial
  begin
    repeat (80000) @(posedge mclk);
    bad_count++;
    stop_test;
  end

  initial
  begin
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    // rows load the divisor, then clear its select before data use
    for (j = 0; j < NROW; j++)
    begin
      if (rows[j].w)
        wr(rows[j].a, rows[j].v);
      else
      begin
        rd(rows[j].a, d);
        chk($sformatf("register row %0d", j), d, rows[j].v);
      end
    end
    rd(B0, d);
    rd(B0, d);
    // second character only after the holding-empty flag returns
    wr(B0, 8'h55);
    for (j = 0; j < 200; j++)
    begin
      rd(B0 + 16'h5, d);
      if (d[5] === 1'b1)
        break;
    end
    wr(B0, 8'hA6);
    for (j = 0; j < 12000 && u_term.rx_q.size() < 2; j++)
      @(posedge mclk);
    chk("sent char 0", u_term.rx_q[0], 8'h55);
    chk("sent char 1", u_term.rx_q[1], 8'hA6);
    wr(B1 + 16'h4, 8'h02);
    #1;
    chk("manual driver on", {7'h00, tx_de[1]}, 8'h01);
    // automatic mode ignores a set request-to-send while idle
    @(posedge mclk);
    auto_mode <= 4'h3;
    @(posedge mclk);
    #1;
    chk("auto driver idle", {7'h00, tx_de[1]}, 8'h00);
    @(posedge mclk);
    auto_mode <= 4'h1;
    wr(B1 + 16'h4, 8'h00);
    #1;
    chk("manual driver off", {7'h00, tx_de[1]}, 8'h00);
    // standard range: divisor 1 gives 16 reference periods, near 1736 cycles
    @(posedge mclk);
    range_x4 <= 1'b0;
    wr(B1 + 16'h3, 8'h83);
    wr(B1, 8'h01);
    wr(B1 + 16'h1, 8'h00);
    wr(B1 + 16'h3, 8'h03);
    wr(B1, 8'h55);
    @(negedge txd[1]);
    for (j = 0; j < 3000 && txd[1] === 1'b0; j++)
      @(negedge mclk);
    chk("standard start bit", {7'h00, j > 1700 && j < 1770}, 8'h01);
    @(posedge mclk);
    range_x4 <= 1'b1;
    // Four unread characters: buffer fills, third stalls, fourth overruns
    u_term.send(8'h11);
    u_term.send(8'h22);
    u_term.send(8'h33);
    u_term.send(8'h44);
    rd(B0 + 16'h5, d);
    chk("flags at overrun", d, 8'h63);
    rd(B0 + 16'h5, d);
    chk("flags after read", d, 8'h61);
    rd(B0 + 16'h2, d);
    chk("ident rx", d, 8'h04);
    rd(B0, d);
    chk("rx char 0", d, 8'h11);
    rd(B0 + 16'h5, d);
    chk("flags still ready", d, 8'h61);
    rd(B0, d);
    chk("rx char 1", d, 8'h22);
    // Drain what is left so the ready state must fall
    for (j = 0; j < 3; j++)
    begin
      rd(B0 + 16'h5, d);
      if (d[0] === 1'b1)
        rd(B0, d);
    end
    rd(B0 + 16'h5, d);
    chk("flags drained", d, 8'h60);
    rd(B0 + 16'h2, d);
    chk("ident drained", d, 8'h01);
    stop_test;
  end
endmodule // qrs_uart_tb
